// ---- hw/countdown_timer_pkg.sv ----
// Purpose: shared constants and carrier types for the periodic countdown timer
// Assumes: system clock of 10 MHz (100 ns period)
// Notes: timing counts are derived from the printed times by expression
package countdown_timer_pkg;

  // widths
  localparam int unsigned COUNT_W = 12;
  localparam int unsigned RTN_W = 17;

  // source rate select encodings
  localparam logic [1:0] SEL_4096HZ = 2'h0;
  localparam logic [1:0] SEL_64HZ = 2'h1;
  localparam logic [1:0] SEL_1HZ = 2'h2;
  localparam logic [1:0] SEL_1MIN = 2'h3;

  // count values
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 12'h000;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 12'h001;
  localparam logic [COUNT_W-1:0] PRESET_RESET = 12'h000;

  // clock period and auto-return times in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned IRQ_RTN_FAST_NS = 122000;
  localparam int unsigned IRQ_RTN_SLOW_NS = 7813000;

  // longest times round down, never below one cycle
  localparam int unsigned IRQ_RTN_FAST_CYC =
    (IRQ_RTN_FAST_NS / CLK_PERIOD_NS) < 1 ? 1 : (IRQ_RTN_FAST_NS / CLK_PERIOD_NS);
  localparam int unsigned IRQ_RTN_SLOW_CYC =
    (IRQ_RTN_SLOW_NS / CLK_PERIOD_NS) < 1 ? 1 : (IRQ_RTN_SLOW_NS / CLK_PERIOD_NS);

  // control bits that software sets through the serial interface
  typedef struct packed {
    logic [1:0] rateSel;
    logic irqEnable;
    logic clockStop;
    logic internalReset;
  } timer_ctrl_t;

  // one-cycle ticks from the divider chain
  typedef struct packed {
    logic tick1min;
    logic tick1hz;
    logic tick64hz;
    logic tick4096hz;
  } rate_ticks_t;

  // timer interrupt drive state
  typedef enum logic {IRQ_IDLE, IRQ_LOW} irq_state_t;

endpackage

// ---- hw/periodic_countdown_interrupt_timer.sv ----
// Purpose: periodic 12-bit countdown timer with event flag and shared open-drain irq
// Assumes: all inputs synchronous to clk_sys; ticks are one-cycle pulses
// Notes: run-bit write strobe is given at the serial clock fall ending data bit 0
`timescale 1ns/1ps

module periodic_countdown_interrupt_timer
  import countdown_timer_pkg::*;
#(
  parameter int unsigned RTN_FAST_CYC = IRQ_RTN_FAST_CYC,
  parameter int unsigned RTN_SLOW_CYC = IRQ_RTN_SLOW_CYC
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire timer_ctrl_t ctrl,
  input wire rate_ticks_t ticks,
  input wire logic runWrStb,
  input wire logic runWrData,
  input wire logic presetWrStb,
  input wire logic [COUNT_W-1:0] presetWrData,
  input wire logic flagWrStb,
  input wire logic flagWrData,
  input wire logic otherIrqLow,
  output logic timerRun,
  output logic timerEventFlag,
  output logic [COUNT_W-1:0] countRead,
  output logic irqOut,
  output logic irqOe
);

  logic timerRun_q;
  logic [COUNT_W-1:0] preset_q;
  logic [COUNT_W-1:0] count_q;
  logic flag_q;
  irq_state_t irqState_q;
  logic [RTN_W-1:0] rtnCnt_q;
  logic sourceTick;
  logic counting;
  logic timerEvent;
  logic startPulse;
  logic [RTN_W-1:0] rtnLoad;

  // source tick mux
  always_comb
  begin
    case (ctrl.rateSel)
      SEL_4096HZ: sourceTick = ticks.tick4096hz;
      SEL_64HZ: sourceTick = ticks.tick64hz;
      SEL_1HZ: sourceTick = ticks.tick1hz;
      SEL_1MIN: sourceTick = ticks.tick1min;
      default: sourceTick = 1'b0;
    endcase
  end

  // counting is gated by run, stop, internal reset and a non-zero preset
  assign counting = timerRun_q && !ctrl.clockStop && !ctrl.internalReset
    && (preset_q != COUNT_ZERO);
  assign timerEvent = counting && sourceTick && (count_q == COUNT_LAST);
  // the write strobe lands on the falling serial clock that ends bit 0
  assign startPulse = runWrStb && runWrData && !timerRun_q;
  assign rtnLoad = (ctrl.rateSel == SEL_4096HZ) ? RTN_W'(RTN_FAST_CYC - 1)
    : RTN_W'(RTN_SLOW_CYC - 1);

  // run bit
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      timerRun_q <= 1'b0;
    else if (runWrStb)
      timerRun_q <= runWrData;
  end

  // preset store; host is expected to stop the timer first
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      preset_q <= PRESET_RESET;
    else if (presetWrStb)
      preset_q <= presetWrData;
  end

  // down counter; free-running ticks make the first interval up to one tick short
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      count_q <= PRESET_RESET;
    else if (startPulse)
      count_q <= preset_q;
    else if (!timerRun_q)
      count_q <= preset_q; // stopped count tracks preset so no partial count survives
    else if (counting && sourceTick)
    begin
      if (count_q == COUNT_LAST || count_q == COUNT_ZERO)
        count_q <= preset_q;
      else
        count_q <= count_q - COUNT_LAST;
    end
  end

  // event flag: a set in the clearing cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      flag_q <= 1'b0;
    else if (timerEvent)
      flag_q <= 1'b1;
    else if (flagWrStb && !flagWrData)
      flag_q <= 1'b0;
  end

  // timer irq drive; run and flag writes deliberately do not release it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      irqState_q <= IRQ_IDLE;
      rtnCnt_q <= '0;
    end
    else
    begin
      case (irqState_q)
        IRQ_IDLE:
        begin
          if (timerEvent && ctrl.irqEnable)
          begin
            irqState_q <= IRQ_LOW;
            rtnCnt_q <= rtnLoad;
          end
        end
        IRQ_LOW:
        begin
          if (!ctrl.irqEnable)
            irqState_q <= IRQ_IDLE;
          else if (timerEvent)
            rtnCnt_q <= rtnLoad; // next event restarts the low time
          else if (rtnCnt_q == '0)
            irqState_q <= IRQ_IDLE;
          else
            rtnCnt_q <= rtnCnt_q - RTN_W'(1);
        end
        default: irqState_q <= IRQ_IDLE;
      endcase
    end
  end

  // age of the current timer low phase, counted from entry or the latest event;
  // kept outside the drive logic so the return-time check does not lean on rtnCnt_q
  logic [RTN_W-1:0] lowAge_q;

  // a long window like the fast return is counted here instead of in a delay range,
  // which keeps the checks cheap for the tools whatever the return counts are set to
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      lowAge_q <= '0;
    else if (irqState_q != IRQ_LOW || timerEvent)
      lowAge_q <= '0;
    else if (lowAge_q != '1)
      lowAge_q <= lowAge_q + RTN_W'(1); // saturates so a stuck pin cannot wrap back
  end

  // registered outputs; the pin is shared with the other interrupt sources
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      timerRun <= 1'b0;
      timerEventFlag <= 1'b0;
      countRead <= PRESET_RESET;
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end
    else
    begin
      timerRun <= timerRun_q;
      timerEventFlag <= flag_q;
      countRead <= timerRun_q ? count_q : preset_q;
      irqOut <= 1'b0; // open drain only ever pulls low
      irqOe <= (irqState_q == IRQ_LOW) || otherIrqLow;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  readback_preset_a: assert property (!timerRun_q |=> countRead == $past(preset_q))
    else $error("stopped readback differs from preset");
  stop_halts_a: assert property (!timerRun_q |-> !timerEvent)
    else $error("event while timer stopped");
  stop_keeps_irq_a: assert property (
    (irqState_q == IRQ_LOW) && runWrStb && !runWrData && ctrl.irqEnable && rtnCnt_q != '0
    |=> irqState_q == IRQ_LOW)
    else $error("run clear released irq");
  start_preset_a: assert property (startPulse |=> count_q == $past(preset_q))
    else $error("start did not load preset");
  flag_set_a: assert property (timerEvent |=> flag_q)
    else $error("event did not set flag");
  flag_hold_a: assert property (flag_q && !(flagWrStb && !flagWrData) |=> flag_q)
    else $error("flag dropped without clear");
  flag_clear_a: assert property (flagWrStb && !flagWrData && !timerEvent |=> !flag_q)
    else $error("flag not cleared");
  irq_assert_a: assert property (timerEvent && ctrl.irqEnable |=> ##1 irqOe)
    else $error("enabled event did not pull pin");
  irq_disable_a: assert property (
    !ctrl.irqEnable && !otherIrqLow ##1 !ctrl.irqEnable && !otherIrqLow
    |=> !irqOe)
    else $error("pin low while timer irq disabled");
  shared_pin_a: assert property (otherIrqLow |=> irqOe)
    else $error("other source not reflected on pin");
  reload_a: assert property (timerEvent |=> count_q == $past(preset_q))
    else $error("no reload after event");
  // the low phase length follows the select at the event; a select change while
  // low is a host hazard, so each check only judges phases under its own select
  fast_return_a: assert property (
    (irqState_q == IRQ_LOW) && (ctrl.rateSel == SEL_4096HZ)
    |-> lowAge_q <= RTN_W'(RTN_FAST_CYC))
    else $error("fast auto-return too late");
  slow_return_a: assert property (
    (irqState_q == IRQ_LOW) && (ctrl.rateSel != SEL_4096HZ)
    |-> lowAge_q <= RTN_W'(RTN_SLOW_CYC))
    else $error("slow auto-return too late");
  irq_release_a: assert property (
    (irqState_q == IRQ_LOW) && !ctrl.irqEnable |=> irqState_q == IRQ_IDLE)
    else $error("disabled timer irq not released");
  event_low_a: assert property (
    timerEvent && ctrl.irqEnable |=> irqState_q == IRQ_LOW)
    else $error("enabled event did not enter low");
  open_drain_a: assert property (!irqOut)
    else $error("pin data not held low");
  flag_out_a: assert property (timerEventFlag == $past(flag_q))
    else $error("flag output not following flag");
  run_out_a: assert property (timerRun == $past(timerRun_q))
    else $error("run output not following run bit");
  rate_fast_a: assert property (ctrl.rateSel == SEL_4096HZ |-> sourceTick == ticks.tick4096hz)
    else $error("fast source not selected");
  rate_minute_a: assert property (ctrl.rateSel == SEL_1MIN |-> sourceTick == ticks.tick1min)
    else $error("minute source not selected");
  stop_gate_a: assert property (ctrl.clockStop || ctrl.internalReset |-> !timerEvent)
    else $error("event under stop or reset");
  zero_preset_a: assert property (preset_q == COUNT_ZERO |-> !timerEvent)
    else $error("event with zero preset");
  decrement_a: assert property (counting && sourceTick && count_q > COUNT_LAST
    |=> count_q == $past(count_q) - COUNT_LAST)
    else $error("count did not step by one");

  start_c: cover property (startPulse ##[1:50] timerEvent);
  auto_return_c: cover property (irqState_q == IRQ_LOW ##1 irqState_q == IRQ_IDLE);
  set_wins_c: cover property (timerEvent && flagWrStb && !flagWrData);
  two_events_c: cover property (timerEvent ##[1:100] timerEvent);
  shared_low_c: cover property (otherIrqLow && (irqState_q == IRQ_IDLE));

endmodule // periodic_countdown_interrupt_timer

// ---- tb/rate_tick_source.sv ----
// Purpose: stand-in divider chain giving one-cycle rate ticks
// Assumes: the four rates are scaled down to a few clock cycles each
// Notes: one shared count keeps every tick in a fixed, known phase
`timescale 1ns/1ps
module rate_tick_source
  import countdown_timer_pkg::*;
#(
  parameter int unsigned DIV0 = 8,
  parameter int unsigned DIV1 = 12,
  parameter int unsigned DIV2 = 16,
  parameter int unsigned DIV3 = 24
)
(
  input wire logic clk_sys,
  input wire logic srst,
  output rate_ticks_t ticks
);
  int unsigned tickCount_q;

  // free-running count; dividing one count avoids drift between rates
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      tickCount_q <= 0;
    else
      tickCount_q <= tickCount_q + 1;
  end

  // one pulse per divided period
  assign ticks.tick4096hz = (tickCount_q % DIV0) == 0;
  assign ticks.tick64hz = (tickCount_q % DIV1) == 0;
  assign ticks.tick1hz = (tickCount_q % DIV2) == 0;
  assign ticks.tick1min = (tickCount_q % DIV3) == 0;
endmodule // rate_tick_source

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the periodic countdown timer
// Assumes: short auto-return counts of 5 and 20 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench
  import countdown_timer_pkg::*;
;
  localparam int unsigned DIVS[4] = '{8, 12, 16, 24};
  logic clk_sys, srst, runWrStb, runWrData, presetWrStb, flagWrStb, flagWrData, otherIrqLow;
  logic [COUNT_W-1:0] presetWrData, countRead;
  logic timerRun, timerEventFlag, irqOut, irqOe;
  timer_ctrl_t ctrl;
  rate_ticks_t ticks;
  int fails, n_tests, n1, n2;

  // divider defaults match DIVS
  rate_tick_source src (.clk_sys(clk_sys), .srst(srst), .ticks(ticks));
  periodic_countdown_interrupt_timer #(.RTN_FAST_CYC(5), .RTN_SLOW_CYC(20)) dut (
    .clk_sys(clk_sys), .srst(srst), .ctrl(ctrl), .ticks(ticks), .runWrStb(runWrStb),
    .runWrData(runWrData), .presetWrStb(presetWrStb), .presetWrData(presetWrData),
    .flagWrStb(flagWrStb), .flagWrData(flagWrData), .otherIrqLow(otherIrqLow),
    .timerRun(timerRun), .timerEventFlag(timerEventFlag), .countRead(countRead),
    .irqOut(irqOut), .irqOe(irqOe));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // one strobe for one edge, then two edges for outputs to follow
  task automatic strobe(input int which, input logic [11:0] v);
    runWrStb = (which == 0);
    presetWrStb = (which == 1);
    flagWrStb = (which == 2);
    runWrData = v[0];
    flagWrData = v[0];
    presetWrData = v;
    step(1);
    runWrStb = 1'b0;
    presetWrStb = 1'b0;
    flagWrStb = 1'b0;
    step(2);
  endtask

  // stop, load, start: preset is only written while stopped
  task automatic restart(input logic [11:0] p);
    strobe(0, 12'h000);
    strobe(1, p);
    strobe(0, 12'h001);
  endtask

  // cycles until the pin drive rises; bounded so a silent timer cannot hang
  task automatic wait_irq(output int n);
    logic prev;
    n = 0;
    prev = irqOe;
    do
    begin
      prev = irqOe;
      step(1);
      n++;
    end
    while (!(prev === 1'b0 && irqOe === 1'b1) && n < 400);
  endtask

  task automatic s_rates();
    ctrl.irqEnable = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      ctrl.rateSel = s[1:0];
      restart(12'h003);
      wait_irq(n1);
      check(n1 <= 3 * DIVS[s] + 2, 1);
      wait_irq(n2);
      check(n2, 3 * DIVS[s]);
      check(timerEventFlag, 1'b1);
    end
    // slow select now: pin stays low for 20 cycles
    strobe(2, 12'h001);
    check(timerEventFlag, 1'b1);
    strobe(2, 12'h000);
    check({timerEventFlag, irqOe, irqOut}, 3'b010);
    strobe(0, 12'h000);
    check({timerRun, irqOe, countRead}, {2'b01, 12'h003});
    step(20);
    check(irqOe, 1'b0);
  endtask

  task automatic s_gating();
    ctrl.irqEnable = 1'b0;
    ctrl.rateSel = SEL_4096HZ;
    restart(12'h003);
    step(60);
    check({timerEventFlag, irqOe}, 2'b10);
    otherIrqLow = 1'b1;
    step(3);
    check(irqOe, 1'b1);
    otherIrqLow = 1'b0;
    ctrl.clockStop = 1'b1;
    strobe(2, 12'h000);
    step(60);
    check(timerEventFlag, 1'b0);
    ctrl.clockStop = 1'b0;
    ctrl.internalReset = 1'b1;
    strobe(2, 12'h000);
    step(60);
    check(timerEventFlag, 1'b0);
    ctrl.internalReset = 1'b0;
    restart(12'h000);
    step(60);
    check(timerEventFlag, 1'b0);
  endtask

  task automatic complete_run();
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    fails++;
    complete_run();
  end

  initial
  begin
    fails = 0;
    n_tests = 0;
    srst = 1'b1;
    ctrl = '0;
    {runWrStb, runWrData, presetWrStb, flagWrStb, flagWrData, otherIrqLow} = '0;
    presetWrData = 12'h000;
    step(2);
    srst = 1'b0;
    strobe(1, 12'h005);
    check({timerRun, countRead}, {1'b0, 12'h005});
    s_rates();
    s_gating();
    complete_run();
  end
endmodule // testbench
